// file: src/txcmd_pkg.sv
// shared field layout, state types and size helpers for the transmit command link
package txcmd_pkg;
   // ==========================================================
   // command word A fields
   localparam int A_IOC_BIT = 31;
   localparam int A_RSVD_HI = 30;
   localparam int A_RSVD_LO = 26;
   localparam int A_ALIGN_LO = 24;
   localparam int A_OFFSET_LO = 16;
   localparam int A_FIRST_BIT = 13;
   localparam int A_LAST_BIT = 12;
   localparam int A_COUNT_LO = 0;
   // ==========================================================
   // command word B fields
   localparam int B_TAG_LO = 16;
   localparam int B_LEN_LO = 0;
   // ==========================================================
   // end alignment codes
   localparam logic [1:0] ALIGN_4 = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   localparam logic [1:0] ALIGN_RSVD = 2'h3;
   localparam logic [9:0] WORDS_16 = 10'h004;
   localparam logic [9:0] WORDS_32 = 10'h008;
   // ==========================================================
   // reset values
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [9:0] IDX_RESET = 10'h000;
   // ==========================================================
   // state machines
   typedef enum logic [1:0] {
      DEV_CMD_A = 2'h0,
      DEV_CMD_B = 2'h1,
      DEV_DATA = 2'h3
   } dev_state_type;
   typedef enum logic [1:0] {
      HOST_IDLE = 2'h0,
      HOST_CMD_A = 2'h1,
      HOST_CMD_B = 2'h3,
      HOST_DATA = 2'h2
   } host_state_type;
   // ==========================================================
   // helpers
   // dwords spanned by offset plus byte count
   function automatic logic [9:0] data_words(input logic [4:0] off,
                                             input logic [10:0] cnt);
      logic [11:0] s;
      s = 12'({7'h00, off}) + 12'({1'h0, cnt}) + 12'h003;
      return s[11:2];
   endfunction
   // dword count rounded up to the end alignment; reserved acts as 4-byte
   function automatic logic [9:0] padded_words(input logic [9:0] w,
                                               input logic [1:0] al);
      logic [9:0] m;
      m = 10'h001;
      if (al == ALIGN_16) begin
         m = WORDS_16;
      end else if (al == ALIGN_32) begin
         m = WORDS_32;
      end
      return (w + m - 10'h001) & ~(m - 10'h001);
   endfunction
   // byte lanes of dword idx that fall inside [off, off+cnt)
   function automatic logic [3:0] keep_mask(input logic [9:0] idx,
                                            input logic [4:0] off,
                                            input logic [10:0] cnt);
      logic [11:0] p;
      logic [11:0] e;
      logic [3:0] k;
      e = 12'({7'h00, off}) + 12'({1'h0, cnt});
      k = 4'h0;
      for (int j = 0; j < 4; j++) begin
         p = {idx, 2'h0} + 12'(j);
         k[j] = (p >= 12'({7'h00, off})) && (p < e);
      end
      return k;
   endfunction
endpackage

// file: src/txcmd_if.sv
// word link carrying commands, payload and padding from host to device
`timescale 1ns/1ps
interface txcmd_if;
   logic [31:0] word;
   logic valid;
   logic ready;
   modport host (output word, output valid, input ready);
   modport device (input word, input valid, output ready);
endinterface

// file: src/tx_buffer_writer.sv
// host end: writes command pair, payload and padding for each buffer
`timescale 1ns/1ps
module tx_buffer_writer (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   txcmd_if.host LINK,
   input wire logic CMD_VALID_I,
   input wire logic [31:0] CMD_A_I,
   input wire logic [31:0] CMD_B_I,
   output logic CMD_READY_O,
   input wire logic DATA_VALID_I,
   input wire logic [31:0] DATA_I,
   output logic DATA_READY_O
);
   // ==========================================================
   // state
   typedef struct packed {
      txcmd_pkg::host_state_type state;
      logic [31:0] word;
      logic valid;
      logic cmd_ready;
      logic data_ready;
      logic [31:0] b_word;
      logic [31:0] saved_b;
      logic [9:0] cnt;
      logic [9:0] nwords;
      logic [9:0] npad;
   } host_regs_type;

   host_regs_type r_reg;
   host_regs_type r_next;
   logic [31:0] a_clean;
   logic sent;

   assign LINK.word = r_reg.word;
   assign LINK.valid = r_reg.valid;
   assign CMD_READY_O = r_reg.cmd_ready;
   assign DATA_READY_O = r_reg.data_ready;

   // ==========================================================
   // next state
   always_comb begin
      r_next = r_reg;
      a_clean = CMD_A_I;
      a_clean[txcmd_pkg::A_RSVD_HI:txcmd_pkg::A_RSVD_LO] = 5'h00;
      if (CMD_A_I[txcmd_pkg::A_ALIGN_LO +: 2] == txcmd_pkg::ALIGN_RSVD) begin
         a_clean[txcmd_pkg::A_ALIGN_LO +: 2] = txcmd_pkg::ALIGN_4;
      end
      sent = r_reg.valid && LINK.ready;
      case (r_reg.state)
         txcmd_pkg::HOST_IDLE: begin
            if (CMD_VALID_I && r_reg.cmd_ready) begin
               r_next.cmd_ready = 1'b0;
               r_next.word = a_clean;
               r_next.valid = 1'b1;
               r_next.state = txcmd_pkg::HOST_CMD_A;
               r_next.cnt = txcmd_pkg::IDX_RESET;
               r_next.nwords = txcmd_pkg::data_words(
                  a_clean[txcmd_pkg::A_OFFSET_LO +: 5],
                  a_clean[txcmd_pkg::A_COUNT_LO +: 11]);
               r_next.npad = txcmd_pkg::padded_words(r_next.nwords,
                  a_clean[txcmd_pkg::A_ALIGN_LO +: 2]);
               // later buffers reuse the first buffer's word B
               if (a_clean[txcmd_pkg::A_FIRST_BIT]) begin
                  r_next.saved_b = CMD_B_I;
                  r_next.b_word = CMD_B_I;
               end else begin
                  r_next.b_word = r_reg.saved_b;
               end
            end else begin
               // idle after reset also offers the command port
               r_next.cmd_ready = 1'b1;
            end
         end
         txcmd_pkg::HOST_CMD_A: begin
            if (sent) begin
               r_next.word = r_reg.b_word;
               r_next.state = txcmd_pkg::HOST_CMD_B;
            end
         end
         txcmd_pkg::HOST_CMD_B: begin
            if (sent) begin
               r_next.valid = 1'b0;
               if (r_reg.npad == txcmd_pkg::IDX_RESET) begin
                  r_next.state = txcmd_pkg::HOST_IDLE;
                  r_next.cmd_ready = 1'b1;
               end else begin
                  r_next.state = txcmd_pkg::HOST_DATA;
                  r_next.data_ready = 1'b1;
               end
            end
         end
         default: begin
            if (sent) begin
               r_next.valid = 1'b0;
               r_next.cnt = r_reg.cnt + 10'h001;
               if (r_next.cnt == r_reg.npad) begin
                  r_next.state = txcmd_pkg::HOST_IDLE;
                  r_next.cmd_ready = 1'b1;
               end else if (r_next.cnt < r_reg.nwords) begin
                  r_next.data_ready = 1'b1;
               end else begin
                  r_next.word = txcmd_pkg::WORD_RESET;
                  r_next.valid = 1'b1;
               end
            end else if (!r_reg.valid && r_reg.data_ready && DATA_VALID_I) begin
               r_next.word = DATA_I;
               r_next.valid = 1'b1;
               r_next.data_ready = 1'b0;
            end
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         r_reg <= '0;
         r_reg.state <= txcmd_pkg::HOST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// file: src/tx_buffer_command_decoder.sv
// device end: decodes command pairs, checks packet consistency, strips padding
// Notes on behaviour
// - first two dwords per buffer are A, B
// - word B tag goes into completion status
// - host writes A and B every buffer
// - differing word B in packet raises error
// - A bit 31 raises done after buffer
// - host writes zero in A bits 30:26
// - A bits 25:24 choose 4/16/32 alignment
// - padding dwords are dropped, never forwarded
// - A bits 20:16 skip leading bytes
// - A bits 13/12 mark first, last buffer
// - summed byte counts checked against B length
// - tag taken from B bits 31:16
`timescale 1ns/1ps
module tx_buffer_command_decoder (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   txcmd_if.device LINK,
   output logic [31:0] OUT_DATA_O,
   output logic [3:0] OUT_KEEP_O,
   output logic OUT_LAST_O,
   output logic OUT_VALID_O,
   input wire logic OUT_READY_I,
   output logic [15:0] STATUS_TAG_O,
   output logic STATUS_VALID_O,
   output logic TRANSMITTER_ERROR_FLAG_O,
   input wire logic ERROR_CLEAR_I,
   output logic TRANSMIT_DONE_FLAG_O,
   input wire logic DONE_CLEAR_I
);
   // ==========================================================
   // state
   typedef struct packed {
      txcmd_pkg::dev_state_type state;
      logic ioc;
      logic [1:0] align;
      logic [4:0] offset;
      logic first;
      logic last;
      logic [10:0] count;
      logic [31:0] pkt_b;
      logic in_pkt;
      logic [15:0] total;
      logic [9:0] idx;
      logic [9:0] nwords;
      logic [9:0] npad;
      logic [31:0] out_data;
      logic [3:0] out_keep;
      logic out_last;
      logic out_valid;
      logic [31:0] skid_data;
      logic [3:0] skid_keep;
      logic skid_last;
      logic skid_valid;
      logic link_ready;
      logic [15:0] tag;
      logic stat_valid;
      logic err;
      logic done;
   } dev_regs_type;

   dev_regs_type r_reg;
   dev_regs_type r_next;
   logic acc;
   logic fin;
   logic push;
   logic [31:0] push_data;
   logic [3:0] push_keep;
   logic push_last;
   logic [31:0] w;

   assign LINK.ready = r_reg.link_ready;
   assign OUT_DATA_O = r_reg.out_data;
   assign OUT_KEEP_O = r_reg.out_keep;
   assign OUT_LAST_O = r_reg.out_last;
   assign OUT_VALID_O = r_reg.out_valid;
   assign STATUS_TAG_O = r_reg.tag;
   assign STATUS_VALID_O = r_reg.stat_valid;
   assign TRANSMITTER_ERROR_FLAG_O = r_reg.err;
   assign TRANSMIT_DONE_FLAG_O = r_reg.done;

   // ==========================================================
   // next state
   always_comb begin
      r_next = r_reg;
      w = LINK.word;
      acc = LINK.valid && r_reg.link_ready;
      fin = 1'b0;
      push = 1'b0;
      push_data = w;
      push_keep = 4'h0;
      push_last = 1'b0;
      r_next.stat_valid = 1'b0;
      // software clears come first so a same-cycle set wins
      if (ERROR_CLEAR_I) begin
         r_next.err = 1'b0;
      end
      if (DONE_CLEAR_I) begin
         r_next.done = 1'b0;
      end
      case (r_reg.state)
         txcmd_pkg::DEV_CMD_A: begin
            if (acc) begin
               r_next.ioc = w[txcmd_pkg::A_IOC_BIT];
               r_next.align = w[txcmd_pkg::A_ALIGN_LO +: 2];
               r_next.offset = w[txcmd_pkg::A_OFFSET_LO +: 5];
               r_next.first = w[txcmd_pkg::A_FIRST_BIT];
               r_next.last = w[txcmd_pkg::A_LAST_BIT];
               r_next.count = w[txcmd_pkg::A_COUNT_LO +: 11];
               r_next.state = txcmd_pkg::DEV_CMD_B;
            end
         end
         txcmd_pkg::DEV_CMD_B: begin
            if (acc) begin
               r_next.state = txcmd_pkg::DEV_DATA;
               r_next.idx = txcmd_pkg::IDX_RESET;
               r_next.nwords = txcmd_pkg::data_words(r_reg.offset,
                                                      r_reg.count);
               r_next.npad = txcmd_pkg::padded_words(r_next.nwords,
                                                      r_reg.align);
               if (r_reg.first) begin
                  // a new first buffer abandons an unterminated packet
                  if (r_reg.in_pkt) begin
                     r_next.err = 1'b1;
                  end
                  r_next.in_pkt = 1'b1;
                  r_next.pkt_b = w;
                  r_next.total = 16'({5'h00, r_reg.count});
               end else begin
                  if (!r_reg.in_pkt || w != r_reg.pkt_b) begin
                     r_next.err = 1'b1;
                  end
                  r_next.total = r_reg.total + 16'({5'h00, r_reg.count});
               end
               if (r_next.npad == txcmd_pkg::IDX_RESET) begin
                  fin = 1'b1;
               end
            end
         end
         default: begin
            if (acc) begin
               r_next.idx = r_reg.idx + 10'h001;
               if (r_reg.idx < r_reg.nwords) begin
                  push_keep = txcmd_pkg::keep_mask(r_reg.idx, r_reg.offset,
                                                   r_reg.count);
                  push = (push_keep != 4'h0);
                  push_last = r_reg.last &&
                     (r_next.idx == r_reg.nwords);
               end
               // words past nwords are padding and are only counted
               if (r_next.idx == r_reg.npad) begin
                  fin = 1'b1;
               end
            end
         end
      endcase
      if (fin) begin
         r_next.state = txcmd_pkg::DEV_CMD_A;
         if (r_reg.ioc) begin
            r_next.done = 1'b1;
         end
         if (r_reg.last) begin
            r_next.in_pkt = 1'b0;
            r_next.stat_valid = 1'b1;
            r_next.tag = r_next.pkt_b[txcmd_pkg::B_TAG_LO +: 16];
            if (r_next.total !=
                16'({5'h00, r_next.pkt_b[txcmd_pkg::B_LEN_LO +: 11]})) begin
               r_next.err = 1'b1;
            end
         end
      end
      // two-entry output buffer: output register plus skid register
      if (r_reg.out_valid && OUT_READY_I) begin
         r_next.out_valid = r_reg.skid_valid;
         r_next.out_data = r_reg.skid_data;
         r_next.out_keep = r_reg.skid_keep;
         r_next.out_last = r_reg.skid_last;
         r_next.skid_valid = 1'b0;
      end
      if (push) begin
         if (!r_next.out_valid) begin
            r_next.out_valid = 1'b1;
            r_next.out_data = push_data;
            r_next.out_keep = push_keep;
            r_next.out_last = push_last;
         end else begin
            r_next.skid_valid = 1'b1;
            r_next.skid_data = push_data;
            r_next.skid_keep = push_keep;
            r_next.skid_last = push_last;
         end
      end
      // at most one push per cycle, so an empty skid is room enough
      r_next.link_ready = !r_next.skid_valid;
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         r_reg <= '0;
         r_reg.state <= txcmd_pkg::DEV_CMD_A;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// file: tb/tx_buffer_command_decoder_properties.sv
// concurrent checks on the command link and the decoder outputs
`timescale 1ns/1ps
module tx_buffer_command_decoder_properties (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic [31:0] word,
   input wire logic valid,
   input wire logic ready,
   input wire logic OUT_VALID_O,
   input wire logic OUT_READY_I,
   input wire logic [31:0] OUT_DATA_O,
   input wire logic [3:0] OUT_KEEP_O,
   input wire logic STATUS_VALID_O,
   input wire logic [15:0] STATUS_TAG_O,
   input wire logic TRANSMITTER_ERROR_FLAG_O,
   input wire logic ERROR_CLEAR_I,
   input wire logic TRANSMIT_DONE_FLAG_O
);
   logic take;
   assign take = valid && ready;
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_N_I);
   // ==========================================================
   // link and output stream
   link_hold_a: assert property (
      valid && !ready |=> valid && $stable(word))
      else $error("link word changed before taken");
   out_hold_a: assert property (
      OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O))
      else $error("output word changed before taken");
   keep_nonzero_a: assert property (
      OUT_VALID_O |-> OUT_KEEP_O != 4'h0)
      else $error("output word with no byte lanes");
   drain_ready_a: assert property (
      OUT_READY_I [*3] |-> ready)
      else $error("link refused while output drains");
   reset_quiet_a: assert property (disable iff (1'b0)
      !RST_N_I |=> !ready && !OUT_VALID_O && !TRANSMITTER_ERROR_FLAG_O)
      else $error("outputs active after reset edge");
   // ==========================================================
   // status and flags
   tag_change_a: assert property (
      !$stable(STATUS_TAG_O) |-> STATUS_VALID_O)
      else $error("status tag changed without status");
   status_cause_a: assert property (
      $rose(STATUS_VALID_O) |-> $past(take) || $past(take, 2))
      else $error("status without a link transfer");
   done_cause_a: assert property (
      $rose(TRANSMIT_DONE_FLAG_O) |-> $past(take) || $past(take, 2))
      else $error("done flag without a link transfer");
   err_sticky_a: assert property (
      TRANSMITTER_ERROR_FLAG_O && !ERROR_CLEAR_I |=> TRANSMITTER_ERROR_FLAG_O)
      else $error("error flag dropped without clear");
endmodule

// file: tb/test_tx_buffer_command_decoder.sv
// bench: writer and decoder back to back, plus a decoder driven directly
`timescale 1ns/1ps
module test_tx_buffer_command_decoder;
   logic clk, rst_n, cmd_v, cmd_r, dat_v, dat_r, o_last, o_v, o_r;
   logic st_v, err, e_clr, done, d_clr, err2, done2;
   logic [31:0] cmd_a, cmd_b, dat, o_data;
   logic [15:0] tag, tag2;
   logic [3:0] o_keep;
   logic [31:0] a_seen;
   logic [36:0] exp_q[$], got_q[$];
   int err_total, checks_done, st_n;
   txcmd_if lk();
   txcmd_if lk2();
   tx_buffer_writer tx_buffer_writer_i (.CLOCK_I(clk), .RST_N_I(rst_n),
      .LINK(lk.host), .CMD_VALID_I(cmd_v), .CMD_A_I(cmd_a), .CMD_B_I(cmd_b),
      .CMD_READY_O(cmd_r), .DATA_VALID_I(dat_v), .DATA_I(dat),
      .DATA_READY_O(dat_r));
   tx_buffer_command_decoder tx_buffer_command_decoder_i (.CLOCK_I(clk),
      .RST_N_I(rst_n), .LINK(lk.device), .OUT_DATA_O(o_data),
      .OUT_KEEP_O(o_keep), .OUT_LAST_O(o_last), .OUT_VALID_O(o_v),
      .OUT_READY_I(o_r), .STATUS_TAG_O(tag), .STATUS_VALID_O(st_v),
      .TRANSMITTER_ERROR_FLAG_O(err), .ERROR_CLEAR_I(e_clr),
      .TRANSMIT_DONE_FLAG_O(done), .DONE_CLEAR_I(d_clr));
   tx_buffer_command_decoder tx_buffer_command_decoder_i2 (.CLOCK_I(clk),
      .RST_N_I(rst_n), .LINK(lk2.device), .OUT_DATA_O(), .OUT_KEEP_O(),
      .OUT_LAST_O(), .OUT_VALID_O(), .OUT_READY_I(1'b1),
      .STATUS_TAG_O(tag2), .STATUS_VALID_O(), .TRANSMITTER_ERROR_FLAG_O(err2),
      .ERROR_CLEAR_I(e_clr), .TRANSMIT_DONE_FLAG_O(done2),
      .DONE_CLEAR_I(d_clr));
   tx_buffer_command_decoder_properties props_i (.CLOCK_I(clk),
      .RST_N_I(rst_n), .word(lk.word), .valid(lk.valid), .ready(lk.ready),
      .OUT_VALID_O(o_v), .OUT_READY_I(o_r), .OUT_DATA_O(o_data),
      .OUT_KEEP_O(o_keep), .STATUS_VALID_O(st_v), .STATUS_TAG_O(tag),
      .TRANSMITTER_ERROR_FLAG_O(err), .ERROR_CLEAR_I(e_clr),
      .TRANSMIT_DONE_FLAG_O(done));
   // ==========================================================
   // checks and run control
   task automatic fail(input string m);
      err_total++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk_bit(input logic g, input logic e);
      checks_done++;
      if (g !== e) fail("flag mismatch");
   endtask
   task automatic chk_tag(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) fail("tag or count mismatch");
   endtask
   task automatic chk_stream();
      chk_tag(16'(got_q.size()), 16'(exp_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0) begin
         checks_done++;
         if (got_q.pop_front() !== exp_q.pop_front()) fail("output word");
      end
      got_q.delete();
      exp_q.delete();
   endtask
   task automatic close_out();
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // host user side and direct link drivers
   task automatic send_buf(input logic [31:0] a, input logic [31:0] b,
                           input int k, input logic [31:0] base);
      int n;
      @(negedge clk);
      cmd_v = 1'b1;
      cmd_a = a;
      cmd_b = b;
      for (n = 0; !cmd_r && n < 300; n++) @(negedge clk);
      if (n == 300) fail("command not taken");
      @(negedge clk);
      cmd_v = 1'b0;
      for (int i = 0; i < k; i++) begin
         dat_v = 1'b1;
         dat = base + 32'(i);
         for (n = 0; !dat_r && n < 300; n++) @(negedge clk);
         if (n == 300) fail("data word not taken");
         @(negedge clk);
      end
      dat_v = 1'b0;
   endtask
   task automatic put2(input logic [31:0] w);
      int n;
      @(negedge clk);
      lk2.word = w;
      lk2.valid = 1'b1;
      for (n = 0; !lk2.ready && n < 300; n++) @(negedge clk);
      if (n == 300) fail("link word not taken");
   endtask
   task automatic buf2(input logic [31:0] a, input logic [31:0] b);
      put2(a);
      put2(b);
      put2(32'h0BAD_F00D);
      @(negedge clk);
      lk2.valid = 1'b0;
      lk2.word = 32'hF452_0FF2;
      repeat (6) @(negedge clk);
   endtask
   task automatic clear_flags();
      @(negedge clk);
      e_clr = 1'b1;
      d_clr = 1'b1;
      @(negedge clk);
      e_clr = 1'b0;
      d_clr = 1'b0;
      @(negedge clk);
   endtask
   always @(posedge clk) begin
      if (rst_n && o_v && o_r) got_q.push_back({o_keep, o_last, o_data});
      if (rst_n && st_v) st_n++;
      if (rst_n && lk.valid && lk.ready &&
          tx_buffer_command_decoder_i.r_reg.state == txcmd_pkg::DEV_CMD_A)
         a_seen = lk.word;
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #20000;
      fail("watchdog expired");
      close_out();
   end
   // ==========================================================
   // scenarios
   initial begin
      {err_total, checks_done, st_n} = '0;
      {rst_n, cmd_v, dat_v, e_clr, d_clr, lk2.valid} = '0;
      {cmd_a, cmd_b, dat, lk2.word} = '0;
      o_r = 1'b1;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      // one buffer: offset 5, 9 bytes, 32-byte end, completion flag
      send_buf(32'h8205_3009, 32'hBEEF_0009, 4, 32'hA000_0000);
      exp_q = '{{4'hE, 1'b0, 32'hA000_0001}, {4'hF, 1'b0, 32'hA000_0002},
                {4'h3, 1'b1, 32'hA000_0003}};
      repeat (40) @(negedge clk);
      chk_stream();
      chk_bit(done, 1'b1);
      chk_bit(err, 1'b0);
      chk_tag(tag, 16'hBEEF);
      chk_tag(16'(st_n), 16'h0001);
      clear_flags();
      chk_bit(done, 1'b0);
      // two buffers under a stalled consumer until the link refuses
      o_r = 1'b0;
      fork
         begin
            repeat (80) @(negedge clk);
            chk_bit(lk.ready, 1'b0);
            chk_bit(o_v, 1'b1);
            o_r = 1'b1;
         end
         begin
            send_buf(32'h0000_2004, 32'h1234_0007, 1, 32'hB000_0000);
            send_buf(32'h0102_1003, 32'h1234_0007, 2, 32'hC000_0000);
         end
      join
      exp_q = '{{4'hF, 1'b0, 32'hB000_0000}, {4'hC, 1'b0, 32'hC000_0000},
                {4'h1, 1'b1, 32'hC000_0001}};
      repeat (40) @(negedge clk);
      chk_stream();
      chk_bit(err, 1'b0);
      chk_bit(done, 1'b0);
      chk_tag(tag, 16'h1234);
      chk_tag(16'(st_n), 16'h0002);
      // reserved bits and reserved end code are scrubbed by the host end
      send_buf(32'h7F00_3004, 32'h4242_0004, 1, 32'hD000_0000);
      exp_q = '{{4'hF, 1'b1, 32'hD000_0000}};
      repeat (40) @(negedge clk);
      chk_stream();
      chk_tag(16'(a_seen[31:24]), 16'h0000);
      chk_bit(err, 1'b0);
      chk_tag(tag, 16'h4242);
      chk_tag(16'(st_n), 16'h0003);
      // second buffer carries a different word B
      buf2(32'h0000_2004, 32'h5555_0008);
      chk_bit(err2, 1'b0);
      buf2(32'h0000_1004, 32'h5556_0008);
      chk_bit(err2, 1'b1);
      clear_flags();
      chk_bit(err2, 1'b0);
      // byte count short of the packet length
      buf2(32'h0000_3004, 32'h7777_0005);
      chk_bit(err2, 1'b1);
      chk_bit(done2, 1'b0);
      chk_tag(tag2, 16'h7777);
      close_out();
   end
endmodule
